/* File: retry_defines.vh */
`ifndef RETRY_DEFINES_VH
`define RETRY_DEFINES_VH

// Register word offsets
`define ADDR_CTRL        4'h0
`define ADDR_LIMIT       4'h1
`define ADDR_DELAY       4'h2
`define ADDR_FORGET      4'h3
`define ADDR_SLOTS       4'h4
`define ADDR_CLEAR       4'h5
`define ADDR_TOTAL       4'h6
`define ADDR_COUNT2      4'h7
`define ADDR_STATUS      4'h8
`define ADDR_IRQ_STAT    4'h9
`define ADDR_IRQ_MASK    4'hA

// Reset values of the settings
`define RST_ENABLE       1'b0
`define RST_LIMIT        3'h5
`define RST_DELAY        7'h05
`define RST_FORGET       6'h0F
`define RST_SLOT         5'h00

// Setting ranges
`define LIMIT_MIN        3'h1
`define LIMIT_MAX        3'h5
`define DELAY_MIN        7'h05
`define DELAY_MAX        7'h78
`define FORGET_MIN       6'h01
`define FORGET_MAX       6'h3C

// Fault selection codes
`define SEL_NONE         5'h00
`define SEL_LAST_CODE    5'h13
`define SEL_ALL          5'h14

// Starter state at the moment of a trip
`define ST_IDLE          2'h0
`define ST_START         2'h1
`define ST_ACCEL         2'h2
`define ST_RUN           2'h3

// Timebase
`define CLK_HZ           10000000
`define SECOND_CYCLES    (`CLK_HZ)
`define SECONDS_PER_MIN  6'h3C

// Interrupt status bits
`define IRQ_TRIP         0
`define IRQ_RETRY        1
`define IRQ_LOCKOUT      2

`endif

/* File: retry_timebase.v */
`timescale 1ns/10ps
`include "retry_defines.vh"

// ----------------------------------------
// Seconds and minutes tick generator
// ----------------------------------------
module retry_timebase
#(
    parameter SECOND_CYCLES = `SECOND_CYCLES
)
(
    input  wire        core_clk,
    input  wire        nrst,
    output reg         sec_tick,
    output reg         min_tick
);

    reg [23:0] cycle_count;
    reg [5:0]  sec_count;

    // Pulse once per second and once per sixty seconds
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cycle_count <= 24'h000000;
            sec_count   <= 6'h00;
            sec_tick    <= 1'b0;
            min_tick    <= 1'b0;
        end
        else if (cycle_count == SECOND_CYCLES[23:0] - 24'h000001)
        begin
            cycle_count <= 24'h000000;
            sec_tick    <= 1'b1;
            if (sec_count == `SECONDS_PER_MIN - 6'h01)
            begin
                sec_count <= 6'h00;
                min_tick  <= 1'b1;
            end
            else
            begin
                sec_count <= sec_count + 6'h01;
                min_tick  <= 1'b0;
            end
        end
        else
        begin
            cycle_count <= cycle_count + 24'h000001;
            sec_tick    <= 1'b0;
            min_tick    <= 1'b0;
        end
    end

endmodule

/* File: fault_auto_retry_controller.v */
// Contract
// RQ1: Auto reset enable setting, off by default; off means trips latch until manual reset.
// RQ2: Retry limit 1 to 5, default 5; permanent trip when used up.
// RQ3: Wait retry delay, 5 to 120 s, default 5, before auto reset.
// RQ4: Clear attempt counter after fault-free running for 1 to 60 min, default 15.
// RQ5: Restart motor after reset if trip came during start, accel or run.
// RQ6: Trip while idle: reset and return to idle without a start.
// RQ7: Four fault slots, codes 0 to 20, default 0; 0 selects nothing.
// RQ8: Only fault codes matching a slot are auto reset; codes 1 to 19.
// RQ9: Any slot holding 20 makes every listed fault eligible.
// RQ10: Total trip counter counts every trip, readable.
// RQ11: Second trip counter counts trips since last cleared.
// RQ12: Writing YES to clear command zeroes second counter; NO does nothing.
// RQ13: Each auto reset bumps attempts; trip at limit stays latched.
`timescale 1ns/10ps
`include "retry_defines.vh"

module fault_auto_retry_controller
#(
    parameter SECOND_CYCLES = `SECOND_CYCLES
)
(
    input  wire        core_clk,
    input  wire        nrst,
    input  wire        fault_trip,
    input  wire [4:0]  fault_code,
    input  wire [1:0]  starter_state,
    input  wire        manual_reset,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rdata,
    output reg         fault_latched,
    output reg         auto_reset_pulse,
    output reg         restart_pulse,
    output reg         lockout,
    output wire        irq
);

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam S_IDLE    = 2'b00;
    localparam S_WAIT    = 2'b01;
    localparam S_LATCHED = 2'b10;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg        retry_enable;
    reg [2:0]  retry_limit;
    reg [6:0]  retry_delay_seconds;
    reg [5:0]  retry_forget_minutes;
    reg [4:0]  retry_fault_slot [0:3];
    reg [15:0] trip_total_count;
    reg [15:0] trip_since_clear_count;
    reg [2:0]  attempt_count;
    reg [1:0]  state;
    reg [6:0]  delay_count;
    reg [5:0]  forget_count;
    reg        restart_pending;
    reg [2:0]  irq_status;
    reg [2:0]  irq_mask;
    reg [2:0]  next_events;
    wire       sec_tick;
    wire       min_tick;
    wire [3:0] slot_hit;
    wire       eligible;
    wire       clear_trip_count_cmd;
    wire       trip_take;
    wire       retry_ok;
    wire [6:0] limit_clamped;
    wire [6:0] forget_clamped;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    retry_timebase
    #(
        .SECOND_CYCLES (SECOND_CYCLES)
    )
    u_timebase
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .sec_tick (sec_tick),
        .min_tick (min_tick)
    );

    // ----------------------------------------
    // Fault eligibility
    // ----------------------------------------
    // Compare one slot against the trip code
    function slot_match;
        input [4:0] slot;
        input [4:0] code;
        begin
            slot_match = (slot == `SEL_ALL && code != `SEL_NONE && code <= `SEL_LAST_CODE) // RQ9
                      || (slot != `SEL_NONE && slot == code); // RQ7
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_slot
            assign slot_hit[gi] = slot_match(retry_fault_slot[gi], fault_code);
        end
    endgenerate

    assign eligible = |slot_hit; // RQ8
    // Only a trip in idle state is taken; repeats while latched are still counted
    assign trip_take = fault_trip && state == S_IDLE;
    assign retry_ok  = retry_enable && eligible && attempt_count < retry_limit; // RQ1 RQ13
    assign clear_trip_count_cmd = wr_en && addr == `ADDR_CLEAR && wdata[0];

    // Clamp a written value into its documented range
    function [6:0] clamp7;
        input [6:0] v;
        input [6:0] lo;
        input [6:0] hi;
        begin
            if (v < lo)
                clamp7 = lo;
            else if (v > hi)
                clamp7 = hi;
            else
                clamp7 = v;
        end
    endfunction

    // Narrow settings share the wide clamp, then are cut back to their own width
    assign limit_clamped  = clamp7({4'h0, wdata[2:0]}, {4'h0, `LIMIT_MIN}, {4'h0, `LIMIT_MAX});
    assign forget_clamped = clamp7({1'b0, wdata[5:0]}, {1'b0, `FORGET_MIN}, {1'b0, `FORGET_MAX});

    // ----------------------------------------
    // Settings registers
    // ----------------------------------------
    // Out-of-range limit, delay and forget writes are clamped and slots above 20 are cleared, so the sequencer never sees an illegal limit
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            retry_enable         <= `RST_ENABLE; // RQ1
            retry_limit          <= `RST_LIMIT; // RQ2
            retry_delay_seconds  <= `RST_DELAY; // RQ3
            retry_forget_minutes <= `RST_FORGET; // RQ4
            retry_fault_slot[0]  <= `RST_SLOT; // RQ7
            retry_fault_slot[1]  <= `RST_SLOT;
            retry_fault_slot[2]  <= `RST_SLOT;
            retry_fault_slot[3]  <= `RST_SLOT;
            irq_mask             <= 3'h0;
        end
        else if (wr_en)
        begin
            case (addr)
                `ADDR_CTRL:
                    retry_enable <= wdata[0];
                `ADDR_LIMIT:
                    retry_limit <= limit_clamped[2:0]; // RQ2
                `ADDR_DELAY:
                    retry_delay_seconds <= clamp7(wdata[6:0], `DELAY_MIN, `DELAY_MAX); // RQ3
                `ADDR_FORGET:
                    retry_forget_minutes <= forget_clamped[5:0]; // RQ4
                `ADDR_SLOTS:
                begin
                    retry_fault_slot[0] <= (wdata[4:0]   > `SEL_ALL) ? `SEL_NONE : wdata[4:0];
                    retry_fault_slot[1] <= (wdata[12:8]  > `SEL_ALL) ? `SEL_NONE : wdata[12:8];
                    retry_fault_slot[2] <= (wdata[20:16] > `SEL_ALL) ? `SEL_NONE : wdata[20:16];
                    retry_fault_slot[3] <= (wdata[28:24] > `SEL_ALL) ? `SEL_NONE : wdata[28:24];
                end
                `ADDR_IRQ_MASK:
                    irq_mask <= wdata[2:0];
                default:
                    irq_mask <= irq_mask;
            endcase
        end
    end

    // ----------------------------------------
    // Trip statistics
    // ----------------------------------------
    // A trip in the clear cycle counts as the first trip after the clear
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            trip_total_count       <= 16'h0000;
            trip_since_clear_count <= 16'h0000;
        end
        else
        begin
            if (fault_trip)
                trip_total_count <= trip_total_count + 16'h0001; // RQ10
            if (clear_trip_count_cmd)
                trip_since_clear_count <= fault_trip ? 16'h0001 : 16'h0000; // RQ12
            else if (fault_trip)
                trip_since_clear_count <= trip_since_clear_count + 16'h0001; // RQ11
        end
    end

    // ----------------------------------------
    // Retry sequencer
    // ----------------------------------------
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state            <= S_IDLE;
            attempt_count    <= 3'h0;
            delay_count      <= 7'h00;
            forget_count     <= 6'h00;
            restart_pending  <= 1'b0;
            fault_latched    <= 1'b0;
            auto_reset_pulse <= 1'b0;
            restart_pulse    <= 1'b0;
            lockout          <= 1'b0;
        end
        else
        begin
            auto_reset_pulse <= 1'b0;
            restart_pulse    <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (trip_take)
                    begin
                        fault_latched   <= 1'b1;
                        forget_count    <= 6'h00;
                        delay_count     <= 7'h00;
                        restart_pending <= (starter_state != `ST_IDLE); // RQ5 RQ6
                        if (retry_ok)
                            state <= S_WAIT; // RQ3
                        else
                        begin
                            state   <= S_LATCHED; // RQ1 RQ13
                            lockout <= retry_enable && eligible; // RQ2
                        end
                    end
                    else if (min_tick && attempt_count != 3'h0)
                    begin
                        // Fault-free minutes since last trip
                        if (forget_count + 6'h01 >= retry_forget_minutes)
                        begin
                            attempt_count <= 3'h0; // RQ4
                            forget_count  <= 6'h00;
                        end
                        else
                            forget_count <= forget_count + 6'h01;
                    end
                end
                S_WAIT:
                begin
                    if (manual_reset)
                    begin
                        state         <= S_IDLE;
                        fault_latched <= 1'b0;
                    end
                    else if (sec_tick)
                    begin
                        if (delay_count + 7'h01 >= retry_delay_seconds)
                        begin
                            state            <= S_IDLE;
                            fault_latched    <= 1'b0;
                            auto_reset_pulse <= 1'b1;
                            attempt_count    <= attempt_count + 3'h1; // RQ13
                            restart_pulse    <= restart_pending; // RQ5 RQ6
                        end
                        else
                            delay_count <= delay_count + 7'h01; // RQ3
                    end
                end
                S_LATCHED:
                begin
                    // Only the operator can leave; attempts restart from zero
                    if (manual_reset)
                    begin
                        state         <= S_IDLE;
                        fault_latched <= 1'b0;
                        lockout       <= 1'b0;
                        attempt_count <= 3'h0;
                    end
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    always @*
    begin
        next_events = 3'h0;
        next_events[`IRQ_TRIP]    = fault_trip;
        next_events[`IRQ_RETRY]   = auto_reset_pulse;
        next_events[`IRQ_LOCKOUT] = trip_take && !retry_ok;
    end

    // Set wins over a write-one-to-clear in the same cycle
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irq_status <= 3'h0;
        else if (wr_en && addr == `ADDR_IRQ_STAT)
            irq_status <= (irq_status & ~wdata[2:0]) | next_events;
        else
            irq_status <= irq_status | next_events;
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 32'h00000000;
        else if (rd_en)
        begin
            case (addr)
                `ADDR_CTRL:     rdata <= {31'h00000000, retry_enable};
                `ADDR_LIMIT:    rdata <= {29'h00000000, retry_limit};
                `ADDR_DELAY:    rdata <= {25'h0000000, retry_delay_seconds};
                `ADDR_FORGET:   rdata <= {26'h0000000, retry_forget_minutes};
                `ADDR_SLOTS:    rdata <= {3'h0, retry_fault_slot[3], 3'h0, retry_fault_slot[2],
                                          3'h0, retry_fault_slot[1], 3'h0, retry_fault_slot[0]};
                `ADDR_CLEAR:    rdata <= 32'h00000000; // Command reads back NO
                `ADDR_TOTAL:    rdata <= {16'h0000, trip_total_count}; // RQ10
                `ADDR_COUNT2:   rdata <= {16'h0000, trip_since_clear_count}; // RQ11
                `ADDR_STATUS:   rdata <= {24'h000000, lockout, fault_latched, 1'b0, attempt_count, state};
                `ADDR_IRQ_STAT: rdata <= {29'h00000000, irq_status};
                `ADDR_IRQ_MASK: rdata <= {29'h00000000, irq_mask};
                default:        rdata <= 32'h00000000;
            endcase
        end
        else
            rdata <= 32'h00000000;
    end

endmodule

/* File: trip_source.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Protection logic raising fault trips
// ----------------------------------------
module trip_source
(
    input  wire       core_clk,
    output reg        fault_trip,
    output reg  [4:0] fault_code,
    output reg  [1:0] starter_state
);
    // Idle between trips
    initial
    begin
        fault_trip    = 1'b0;
        fault_code    = 5'h1F;
        starter_state = 2'h0;
    end

    // One-cycle trip pulse; code and state are inverted afterwards so the trip values are not left driven
    task raise(input [4:0] code, input [1:0] state);
    begin
        @(posedge core_clk);
        fault_trip    <= 1'b1;
        fault_code    <= code;
        starter_state <= state;
        @(posedge core_clk);
        fault_trip    <= 1'b0;
        fault_code    <= ~code;
        starter_state <= ~state;
    end
    endtask
endmodule

/* File: fault_auto_retry_controller_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the retry sequencer
// ----------------------------------------
module retry_port_checker
#(
    parameter SECOND_CYCLES = 10
)
(
    input wire        core_clk,
    input wire        nrst,
    input wire        fault_trip,
    input wire [4:0]  fault_code,
    input wire [1:0]  starter_state,
    input wire        manual_reset,
    input wire [3:0]  addr,
    input wire [31:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rdata,
    input wire        fault_latched,
    input wire        auto_reset_pulse,
    input wire        restart_pulse,
    input wire        lockout,
    input wire        irq
);
    reg [31:0] held_cycles;
    reg [1:0]  trip_state;

    // Time spent latched, and the starter state of the trip that opened the wait
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            held_cycles <= 32'h0;
            trip_state  <= 2'h0;
        end
        else
        begin
            held_cycles <= fault_latched ? held_cycles + 32'h1 : 32'h0;
            if (fault_trip && !fault_latched)
                trip_state <= starter_state;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_trip_latches : assert property (
        fault_trip && !fault_latched && !manual_reset |=> fault_latched) else $error("trip not latched");
    a_retry_drops_latch : assert property (
        auto_reset_pulse |-> $fell(fault_latched)) else $error("auto reset without latch release");
    a_delay_floor : assert property (
        auto_reset_pulse |-> held_cycles >= 4 * SECOND_CYCLES) else $error("auto reset came too early");
    a_restart_pairing : assert property (
        auto_reset_pulse |-> restart_pulse == (trip_state != 2'h0)) else $error("restart disagrees with state");
    a_restart_only_retry : assert property (
        restart_pulse |-> auto_reset_pulse) else $error("restart without auto reset");
    a_lockout_cause : assert property (
        $rose(lockout) |-> $past(fault_trip)) else $error("lockout without a trip");
    a_manual_clears : assert property (
        manual_reset && !fault_trip |=> !fault_latched && !lockout) else $error("manual reset ignored");
    a_read_idle : assert property (
        !rd_en |=> rdata == 32'h0) else $error("read data outside answer cycle");
endmodule

/* File: fault_auto_retry_controller_bench.sv */
`timescale 1ns/10ps
`include "retry_defines.vh"
// ----------------------------------------
// Bench for the auto retry sequencer
// ----------------------------------------
module fault_auto_retry_controller_bench;
    localparam SEC = 10;
    localparam [31:0] ALL = 32'hFFFFFFFF;
    reg         core_clk;
    reg         nrst;
    reg         manual_reset;
    reg  [3:0]  addr;
    reg  [31:0] wdata;
    reg         wr_en;
    reg         rd_en;
    reg         rd_seen;
    reg  [63:0] note;
    reg  [63:0] rd_q[$];
    reg         ev_q[$];
    reg  [4:0]  code;
    reg  [1:0]  st;
    wire [31:0] rdata;
    wire        fault_trip;
    wire [4:0]  fault_code;
    wire [1:0]  starter_state;
    wire        fault_latched;
    wire        auto_reset_pulse;
    wire        restart_pulse;
    wire        lockout;
    wire        irq;
    integer     failures;
    integer     check_count;
    integer     trips;
    integer     trips2;
    integer     i;

    trip_source src (.core_clk(core_clk), .fault_trip(fault_trip), .fault_code(fault_code),
        .starter_state(starter_state));
    fault_auto_retry_controller #(.SECOND_CYCLES(SEC)) dut (.core_clk(core_clk), .nrst(nrst),
        .fault_trip(fault_trip), .fault_code(fault_code), .starter_state(starter_state),
        .manual_reset(manual_reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .fault_latched(fault_latched), .auto_reset_pulse(auto_reset_pulse),
        .restart_pulse(restart_pulse), .lockout(lockout), .irq(irq));

    task check(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
        end
    end
    endtask

    task complete_run;
    begin
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    end
    endtask

    // The expected answer is noted before the read goes out
    task rd(input [3:0] a, input [31:0] exp, input [31:0] mask);
    begin
        rd_q.push_back({mask, exp});
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
    end
    endtask

    // Six seconds covers the longest wait at the 5 s delay used here
    task trip(input [4:0] c, input [1:0] s, input retry);
    begin
        if (retry)
            ev_q.push_back(s != 2'h0);
        trips = trips + 1;
        trips2 = trips2 + 1;
        src.raise(c, s);
        repeat (6 * SEC) @(posedge core_clk);
        check(ev_q.size(), 32'h0);
    end
    endtask

    task manual;
    begin
        @(posedge core_clk);
        manual_reset <= 1'b1;
        @(posedge core_clk);
        manual_reset <= 1'b0;
    end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Oldest note against each read answer and each auto reset
    always @(posedge core_clk)
        rd_seen <= rd_en;
    always @(negedge core_clk)
    begin
        if (rd_seen === 1'b1)
        begin
            note = rd_q.pop_front();
            check(rdata & note[63:32], note[31:0]);
        end
        if (auto_reset_pulse === 1'b1 && ev_q.size() == 0)
            check(32'h1, 32'h0);
        else if (auto_reset_pulse === 1'b1)
            check({31'h0, restart_pulse}, {31'h0, ev_q.pop_front()});
    end

    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures = failures + 1;
        complete_run;
    end

    initial
    begin
        failures = 0;
        check_count = 0;
        trips = 0;
        trips2 = 0;
        nrst = 1'b0;
        manual_reset = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        i = $urandom(32'h912D933D);
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`ADDR_CTRL, 32'h0, ALL);
        rd(`ADDR_LIMIT, 32'h5, ALL);
        rd(`ADDR_DELAY, 32'h5, ALL);
        rd(`ADDR_FORGET, 32'hF, ALL);
        rd(`ADDR_SLOTS, 32'h0, ALL);
        rd(`ADDR_COUNT2, 32'h0, ALL);
        rd(4'hF, 32'h0, ALL);
        // Settings outside their range are pulled to the nearest end; a slot above 20 is cleared to 0
        wr(`ADDR_LIMIT, 32'h7);
        rd(`ADDR_LIMIT, 32'h5, ALL);
        wr(`ADDR_LIMIT, 32'h0);
        rd(`ADDR_LIMIT, 32'h1, ALL);
        wr(`ADDR_DELAY, 32'h7F);
        rd(`ADDR_DELAY, 32'h78, ALL);
        wr(`ADDR_DELAY, 32'h0);
        rd(`ADDR_DELAY, 32'h5, ALL);
        wr(`ADDR_FORGET, 32'h3F);
        rd(`ADDR_FORGET, 32'h3C, ALL);
        wr(`ADDR_SLOTS, 32'h15140013);
        rd(`ADDR_SLOTS, 32'h00140013, ALL);
        // Disabled: the trip stays latched; interrupt masked, unmasked, cleared
        trip(5'h04, 2'h3, 1'b0);
        rd(`ADDR_STATUS, 32'h40, 32'hFC);
        rd(`ADDR_IRQ_STAT, 32'h1, 32'h1);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ_MASK, 32'h1);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_STAT, 32'h1);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h0);
        manual;
        wr(`ADDR_CLEAR, 32'h1);
        trips2 = 0;
        rd(`ADDR_COUNT2, 32'h0, ALL);
        // Slot match, idle and accelerating retries, then lockout at the limit
        wr(`ADDR_CTRL, 32'h1);
        wr(`ADDR_LIMIT, 32'h2);
        wr(`ADDR_SLOTS, 32'h00000700);
        trip(5'h08, 2'h3, 1'b0);
        manual;
        trip(5'h07, 2'h0, 1'b1);
        trip(5'h07, 2'h2, 1'b1);
        trip(5'h07, 2'h1, 1'b0);
        check({31'h0, lockout}, 32'h1);
        rd(`ADDR_STATUS, 32'hC8, 32'hFC);
        // Trip, auto reset and lockout events have all been flagged by now
        rd(`ADDR_IRQ_STAT, 32'h7, 32'h7);
        manual;
        // A fault-free minute forgets the used attempt
        wr(`ADDR_LIMIT, 32'h1);
        wr(`ADDR_FORGET, 32'h1);
        trip(5'h07, 2'h3, 1'b1);
        repeat (1300) @(posedge core_clk);
        trip(5'h07, 2'h3, 1'b1);
        // Code 20 in one slot makes any listed fault eligible
        wr(`ADDR_LIMIT, 32'h5);
        wr(`ADDR_SLOTS, 32'h14000000);
        for (i = 0; i < 3; i = i + 1)
        begin
            code = $urandom % 19 + 1;
            st = $urandom % 4;
            trip(code, st, 1'b1);
        end
        rd(`ADDR_TOTAL, trips, ALL);
        wr(`ADDR_CLEAR, 32'h0);
        rd(`ADDR_COUNT2, trips2, ALL);
        repeat (3) @(posedge core_clk);
        complete_run;
    end
endmodule

bind fault_auto_retry_controller retry_port_checker #(.SECOND_CYCLES(SECOND_CYCLES)) port_check (
    .core_clk(core_clk), .nrst(nrst), .fault_trip(fault_trip), .fault_code(fault_code),
    .starter_state(starter_state), .manual_reset(manual_reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .fault_latched(fault_latched),
    .auto_reset_pulse(auto_reset_pulse), .restart_pulse(restart_pulse), .lockout(lockout), .irq(irq));
